// >>> cba_asserts.sv
// Purpose: Port-level checks for cba_top
// Assumes: Control word tracked from acked bus writes
// Notes:   Tick divider handed on through bind
`timescale 1ns/10ps
`default_nettype none
module cba_asserts
   import cba_pkg::*;
#(
   parameter int unsigned TICK_DIV = TICK_CYC
) (
   // Watched ports
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic        i_wb_cyc,
   input wire logic        i_wb_stb,
   input wire logic        i_wb_we,
   input wire logic [7:0]  i_wb_adr,
   input wire logic [3:0]  i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic        o_wb_ack,
   input wire logic        i_rx_valid,
   input wire logic        i_rx_sig_present,
   input wire logic        i_rx_sig_busy,
   input wire logic        i_data_ready,
   input wire logic        o_tx_enable,
   input wire logic        o_sig_busy
);
   logic [3:0]  ctrl_ff;
   logic [15:0] vcnt_ff;
   wire logic   dig = ctrl_ff[1:0] == MODE_DIGITAL;
   wire logic   mst = dig & ctrl_ff[CTRL_MASTER];
   wire logic   rem = dig & ~ctrl_ff[CTRL_MASTER];
   // Absent signalling counts as busy
   wire logic   cbusy = ~i_rx_sig_present | i_rx_sig_busy;
   always_ff @(posedge i_clk) begin
      if (i_rst)
         ctrl_ff <= CTRL_RST[3:0];
      else if (i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack & i_wb_adr == REG_CTRL & i_wb_sel[0])
         ctrl_ff <= i_wb_dat[3:0];
   end
   // Length of the current remote burst
   always_ff @(posedge i_clk) begin
      if (i_rst | ~i_rx_valid)
         vcnt_ff <= '0;
      else if (vcnt_ff != 16'hffff)
         vcnt_ff <= vcnt_ff + 16'h1;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_req;
      i_wb_cyc & i_wb_stb & ~o_wb_ack;
   endsequence
   sequence s_burst_end;
      $fell(i_rx_valid);
   endsequence
   ack_follows_a: assert property (s_req |=> o_wb_ack)
      else $error("bus request not acked next cycle");
   ack_pulse_a: assert property (o_wb_ack |=> ~o_wb_ack)
      else $error("ack held over two cycles");
   master_keyed_a: assert property (mst [*3] |-> o_tx_enable)
      else $error("master transmitter not keyed");
   off_pass_a: assert property (~dig [*3] |-> o_tx_enable == $past(i_data_ready))
      else $error("off mode does not follow data ready");
   chan_hold_a: assert property ((rem & cbusy) [*7] |=> ~$rose(o_tx_enable))
      else $error("remote keyed on a busy channel");
   busy_lat_a: assert property ($rose(o_sig_busy) |-> mst && vcnt_ff >= 4 * TICK_DIV
      && vcnt_ff <= 6 * TICK_DIV + 6)
      else $error("busy bit latency out of range");
   busy_set_a: assert property (mst && vcnt_ff > 6 * TICK_DIV + 8 |-> o_sig_busy)
      else $error("busy bit missing during burst");
   busy_clear_a: assert property (s_burst_end |-> ##[1:6] ~o_sig_busy)
      else $error("busy bit not cleared after burst");
endmodule : cba_asserts
bind cba_top cba_asserts #(.TICK_DIV(TICK_DIV)) cba_asserts_i (.i_clk(i_clk), .i_rst(i_rst),
   .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
   .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_ack(o_wb_ack), .i_rx_valid(i_rx_valid),
   .i_rx_sig_present(i_rx_sig_present), .i_rx_sig_busy(i_rx_sig_busy),
   .i_data_ready(i_data_ready), .o_tx_enable(o_tx_enable), .o_sig_busy(o_sig_busy));
`default_nettype wire

// >>> cba_pkg.sv
// Purpose: Shared constants for the channel-busy backoff controller
// Assumes: 25 MHz system clock, 32-bit classic Wishbone register access
// Notes:   Byte offsets of the register words are aligned to four
package cba_pkg;

   // Clock and tick timing
   localparam int unsigned CLK_HZ        = 25000000;
   localparam int unsigned TICK_MS       = 1;
   localparam int unsigned TICK_CYC      = (CLK_HZ / 1000) * TICK_MS;
   // Busy-bit latency from remote start, in ms
   localparam int unsigned BUSY_LAT_MS   = 5;
   localparam int unsigned BUSY_LAT_TICKS = BUSY_LAT_MS / TICK_MS;

   // Register byte offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_TIMING = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;

   // Control register fields
   localparam int unsigned CTRL_MODE_LO   = 0;   // 2 bits: avoidance mode
   localparam int unsigned CTRL_MASTER    = 2;   // 1 master, 0 remote
   localparam int unsigned CTRL_METHOD    = 3;   // 0 retry after, 1 delay before
   // Timing register fields
   localparam int unsigned TIM_SLOTS_LO   = 0;   // 5 bits, 1..16
   localparam int unsigned TIM_SLOTMS_LO  = 8;   // 8 bits, 1..255
   // Status register fields
   localparam int unsigned ST_BUSY_TX     = 0;
   localparam int unsigned ST_CHAN_BUSY   = 1;
   localparam int unsigned ST_BACKOFF     = 2;
   localparam int unsigned ST_TX_EN       = 3;
   localparam int unsigned ST_STATE_LO    = 4;   // 4 bits state code

   // Avoidance modes
   localparam logic [1:0] MODE_OFF     = 2'h0;
   localparam logic [1:0] MODE_DIGITAL = 2'h1;

   // Reset values and slot-count limit
   localparam logic [31:0] CTRL_RST   = 32'h0000_0001;
   localparam logic [4:0]  SLOTS_RST  = 5'h01;
   localparam logic [7:0]  SLOTMS_RST = 8'h01;
   localparam logic [4:0]  SLOTS_MAX  = 5'h10;

   // LFSR seed and taps (16-bit maximal)
   localparam logic [15:0] LFSR_SEED  = 16'hace1;
   localparam logic [15:0] LFSR_TAPS  = 16'hb400;

   // Remote state machine, one-hot
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_WAIT = 4'b0010,
      ST_BOFF = 4'b0100,
      ST_SEND = 4'b1000
   } cba_state_t;

endpackage : cba_pkg

// >>> cba_radio_model.sv
// Purpose: Far-side radio traffic seen by the modem
// Assumes: Bench commands master and remote activity
// Notes:   Missing signalling shows a toggling busy line
`timescale 1ns/10ps
`default_nettype none
module cba_radio_model (
   input  wire logic i_clk,
   input  wire logic i_mst_on,
   input  wire logic i_mst_busy,
   input  wire logic i_rem_tx,
   output logic      o_rx_valid,
   output logic      o_rx_sig_present,
   output logic      o_rx_sig_busy
);
   logic [1:0] lock_ff = 2'h0;
   logic       tog_ff  = 1'b0;
   always_ff @(posedge i_clk) begin
      tog_ff           <= ~tog_ff;
      o_rx_sig_present <= i_mst_on;
      o_rx_sig_busy    <= i_mst_on ? i_mst_busy : tog_ff;
   end
   // Decoder locks a few cycles after carrier
   always_ff @(posedge i_clk) begin
      lock_ff    <= {lock_ff[0], i_rem_tx};
      o_rx_valid <= i_rem_tx & lock_ff[1];
   end
endmodule : cba_radio_model
`default_nettype wire

// >>> cba_rand.sv
// Purpose: Random slot multiplier source
// Assumes: Free-running LFSR, one value per draw
// Notes:   Modulo fold keeps every 1..max reachable, slight bias accepted
`timescale 1ns/10ps
`default_nettype none
module cba_rand
   import cba_pkg::*;
(
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // Draw request
   input  wire logic [4:0] i_max,
   output logic      [4:0] o_mult
);
   logic [15:0] lfsr_ff;
   logic [4:0]  max_c;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         lfsr_ff <= LFSR_SEED;
      end else begin
         lfsr_ff <= lfsr_ff[0] ? ((lfsr_ff >> 1) ^ LFSR_TAPS) : (lfsr_ff >> 1);
      end
   end

   always_comb begin
      max_c = (i_max == 5'h00) ? 5'h01 : i_max;
      o_mult = 5'((lfsr_ff[7:0] % 8'(max_c)) + 8'h01);
   end
endmodule : cba_rand
`default_nettype wire

// >>> cba_tick.sv
// Purpose: Millisecond tick divider
// Assumes: One system clock, synchronous active-high reset
// Notes:   Tick is a one-cycle enable pulse
`timescale 1ns/10ps
`default_nettype none
module cba_tick
   import cba_pkg::*;
#(
   parameter int unsigned DIV = TICK_CYC
) (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst,
   // Tick out
   output logic      o_tick
);
   logic [15:0] cnt_ff;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt_ff <= 16'h0000;
         o_tick <= 1'b0;
      end else if (cnt_ff == 16'(DIV - 1)) begin
         cnt_ff <= 16'h0000;
         o_tick <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 16'h0001;
         o_tick <= 1'b0;
      end
   end
endmodule : cba_tick
`default_nettype wire

// >>> cba_top.sv
// Purpose: Digital collision avoidance for a point-to-multipoint modem
// Assumes: Rx link status inputs come from other clock-domain pins
// Notes:   Registers over classic Wishbone, 32-bit words
`timescale 1ns/10ps
`default_nettype none
module cba_top
   import cba_pkg::*;
#(
   parameter int unsigned TICK_DIV = TICK_CYC
) (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // Wishbone slave
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   // Radio receive side (asynchronous)
   input  wire logic        i_rx_valid,
   input  wire logic        i_rx_sig_present,
   input  wire logic        i_rx_sig_busy,
   // User data path
   input  wire logic        i_data_ready,
   output logic             o_tx_enable,
   output logic             o_sig_busy
);
   logic [31:0] ctrl_ff;
   logic [4:0]  slots_ff;
   logic [7:0]  slotms_ff;
   logic [2:0]  rxv_ff;
   logic [2:0]  rxp_ff;
   logic [2:0]  rxb_ff;
   logic        tick;
   logic [4:0]  mult;
   logic [2:0]  lat_ff;
   logic        busy_ff;
   logic [11:0] boff_ff;
   logic [11:0] nxt_boff;
   logic        tx_ff;
   cba_state_t  state_ff;
   cba_state_t  nxt_state;
   logic        is_off;
   logic        is_master;
   logic        delay_before;
   logic        chan_busy;
   logic        draw;
   logic        wb_req;
   logic        wb_wr;
   logic        wb_rd;

   // Clamp a written slot count into 1..max
   function automatic logic [4:0] clamp_slots(input logic [4:0] v);
      if (v == 5'h00) begin
         return 5'h01;
      end else if (v > SLOTS_MAX) begin
         return SLOTS_MAX;
      end
      return v;
   endfunction : clamp_slots

   // Zero slot time would end every backoff at once
   function automatic logic [7:0] clamp_slotms(input logic [7:0] v);
      return (v == 8'h00) ? 8'h01 : v;
   endfunction : clamp_slotms

   // Timing word as software reads it back
   function automatic logic [31:0] timing_word(input logic [4:0] n, input logic [7:0] ms);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[TIM_SLOTS_LO +: 5]  = n;
      w[TIM_SLOTMS_LO +: 8] = ms;
      return w;
   endfunction : timing_word

   // Status word: state code and live flags
   function automatic logic [31:0] status_word(input cba_state_t s, input logic tx,
                                               input logic cbusy, input logic bbusy);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[ST_STATE_LO +: 4] = s;
      w[ST_TX_EN]         = tx;
      w[ST_BACKOFF]       = (s == ST_BOFF);
      w[ST_CHAN_BUSY]     = cbusy;
      w[ST_BUSY_TX]       = bbusy;
      return w;
   endfunction : status_word

   cba_tick #(.DIV(TICK_DIV)) u_tick (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .o_tick (tick)
   );

   cba_rand u_rand (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_max  (slots_ff),
      .o_mult (mult)
   );

   // Three-stage synchronisers; stage 0 feeds only stage 1
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rxv_ff <= 3'h0;
      end else begin
         rxv_ff <= {rxv_ff[1:0], i_rx_valid};
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rxp_ff <= 3'h0;
      end else begin
         rxp_ff <= {rxp_ff[1:0], i_rx_sig_present};
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rxb_ff <= 3'h0;
      end else begin
         rxb_ff <= {rxb_ff[1:0], i_rx_sig_busy};
      end
   end

   // Bus decode; a write lands only at the edge that sees ack high
   always_comb begin
      wb_req = i_wb_cyc && i_wb_stb;
      wb_wr  = wb_req && i_wb_we && o_wb_ack;
      wb_rd  = wb_req && !i_wb_we && !o_wb_ack;
   end

   // Wishbone: one-cycle ack, dropped after each beat
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_wb_ack <= 1'b0;
      end else begin
         o_wb_ack <= wb_req && !o_wb_ack;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ctrl_ff <= CTRL_RST;
      end else if (wb_wr && i_wb_adr == REG_CTRL && i_wb_sel[0]) begin
         ctrl_ff <= {28'h0000000, i_wb_dat[3:0]};
      end
   end

   // Out-of-range values are clamped to the legal span
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         slots_ff <= SLOTS_RST;
      end else if (wb_wr && i_wb_adr == REG_TIMING && i_wb_sel[0]) begin
         slots_ff <= clamp_slots(i_wb_dat[TIM_SLOTS_LO +: 5]);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         slotms_ff <= SLOTMS_RST;
      end else if (wb_wr && i_wb_adr == REG_TIMING && i_wb_sel[1]) begin
         slotms_ff <= clamp_slotms(i_wb_dat[TIM_SLOTMS_LO +: 8]);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_wb_dat <= 32'h0000_0000;
      end else if (wb_rd) begin
         case (i_wb_adr)
            REG_CTRL:   o_wb_dat <= ctrl_ff;
            REG_TIMING: o_wb_dat <= timing_word(slots_ff, slotms_ff);
            REG_STATUS: o_wb_dat <= status_word(state_ff, tx_ff, chan_busy, busy_ff);
            default:    o_wb_dat <= 32'h0000_0000;
         endcase
      end
   end

   always_comb begin
      is_off       = ctrl_ff[CTRL_MODE_LO +: 2] != MODE_DIGITAL;
      is_master    = ctrl_ff[CTRL_MASTER];
      delay_before = ctrl_ff[CTRL_METHOD];
      chan_busy    = !rxp_ff[2] || rxb_ff[2];
   end

   always_ff @(posedge i_clk) begin
      if (i_rst || is_off || !is_master || !rxv_ff[2]) begin
         lat_ff <= 3'h0;
      end else if (tick && !busy_ff && lat_ff != 3'(BUSY_LAT_TICKS - 1)) begin
         lat_ff <= lat_ff + 3'h1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst || is_off || !is_master || !rxv_ff[2]) begin
         busy_ff <= 1'b0;
      end else if (tick && lat_ff == 3'(BUSY_LAT_TICKS - 1)) begin
         busy_ff <= 1'b1;
      end
   end

   assign o_sig_busy = busy_ff;

   // Remote transmit state machine
   always_comb begin
      nxt_state = state_ff;
      nxt_boff  = boff_ff;
      draw      = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            if (i_data_ready) begin
               if (delay_before) begin
                  draw      = 1'b1;
                  nxt_state = ST_BOFF;
               end else begin
                  nxt_state = ST_WAIT;
               end
            end
         end
         ST_WAIT: begin
            if (!i_data_ready) begin
               nxt_state = ST_IDLE;
            end else if (chan_busy) begin
               draw      = 1'b1;
               nxt_state = ST_BOFF;
            end else begin
               nxt_state = ST_SEND;
            end
         end
         ST_BOFF: begin
            if (boff_ff == 12'h000) begin
               nxt_state = ST_WAIT;
            end else if (tick) begin
               nxt_boff = boff_ff - 12'h001;
            end
         end
         ST_SEND: begin
            if (!i_data_ready) begin
               nxt_state = ST_IDLE;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
      if (draw) begin
         nxt_boff = 12'(mult) * 12'(slotms_ff);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst || is_off || is_master) begin
         state_ff <= ST_IDLE;
         boff_ff  <= 12'h000;
      end else begin
         state_ff <= nxt_state;
         boff_ff  <= nxt_boff;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         tx_ff <= 1'b0;
      end else if (is_off) begin
         tx_ff <= i_data_ready;
      end else if (is_master) begin
         tx_ff <= 1'b1;
      end else begin
         tx_ff <= (nxt_state == ST_SEND);
      end
   end

   assign o_tx_enable = tx_ff;

endmodule : cba_top
`default_nettype wire

// >>> tb_radio_channel_busy_backoff.sv
// Purpose: Register and radio-side tests for the backoff block
// Assumes: Tick divider of 10 cycles
// Notes:   Backoff lengths are binned into slot multiples
`timescale 1ns/10ps
`default_nettype none
module tb_radio_channel_busy_backoff;
   import cba_pkg::*;
   localparam int unsigned DIV = 10;
   logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic        mon = 1'b0, mbusy = 1'b0, rtx = 1'b0, rdy = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic        ack, tx, sbusy, rv, sp, sb;
   logic [4:0]  seen = 5'h00;
   int          mismatches = 0, n_checks = 0, c, k;
   initial forever #20 clk = ~clk;
   cba_radio_model cba_radio_model_i (.i_clk(clk), .i_mst_on(mon), .i_mst_busy(mbusy),
      .i_rem_tx(rtx), .o_rx_valid(rv), .o_rx_sig_present(sp), .o_rx_sig_busy(sb));
   cba_top #(.TICK_DIV(DIV)) cba_top_i (.i_clk(clk), .i_rst(rst), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat),
      .o_wb_dat(rdat), .o_wb_ack(ack), .i_rx_valid(rv), .i_rx_sig_present(sp),
      .i_rx_sig_busy(sb), .i_data_ready(rdy), .o_tx_enable(tx), .o_sig_busy(sbusy));
   task automatic check(input logic [31:0] v, input logic [31:0] e);
      n_checks++;
      if (v !== e) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, v, e);
      end
   endtask : check
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_of_test
   // Request held until ack is sampled high at a rising edge
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      adr  <= a;
      we   <= w;
      wdat <= d;
      do @(posedge clk); while (ack !== 1'b1 && ++t < 50);
      check(ack, 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask : wb
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(a, 1'b0, 32'h0);
      check(q, e);
   endtask : rd
   task automatic pause(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : pause
   task automatic wait_tx(output int n);
      n = 0;
      while (tx !== 1'b1 && n < 600) begin
         @(negedge clk);
         n++;
      end
   endtask : wait_tx
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(REG_CTRL, CTRL_RST);
      rd(REG_TIMING, {16'h0, SLOTMS_RST, 3'h0, SLOTS_RST});
      rd(8'h0c, 32'h0);
      @(posedge clk);
      rdy <= 1'b1;
      pause(150);
      check(tx, 1'b0);
      @(posedge clk);
      mon <= 1'b1;
      wait_tx(c);
      check(c < 25, 1'b1);
      @(posedge clk);
      rdy <= 1'b0;
      wb(REG_TIMING, 1'b1, 32'h0304);
      @(posedge clk);
      mbusy <= 1'b1;
      // Busy must clear the synchronisers before data shows up
      pause(6);
      @(posedge clk);
      rdy   <= 1'b1;
      pause(60);
      check(tx, 1'b0);
      @(posedge clk);
      mbusy <= 1'b0;
      wait_tx(c);
      check(c < 145, 1'b1);
      @(posedge clk);
      rdy <= 1'b0;
      wb(REG_CTRL, 1'b1, 32'h9);
      // Enough draws that every multiplier turns up
      for (int i = 0; i < 24; i++) begin
         pause(2);
         @(posedge clk);
         rdy <= 1'b1;
         wait_tx(c);
         k = (c + 15) / 30;
         check(c >= 30 * k - 10 && c <= 30 * k + 8 && k > 0 && k < 5, 1'b1);
         seen[k] = 1'b1;
         @(posedge clk);
         rdy <= 1'b0;
      end
      check(seen, 5'h1e);
      wb(REG_CTRL, 1'b1, 32'h0);
      @(posedge clk);
      mon <= 1'b0;
      rdy <= 1'b1;
      pause(3);
      check(tx, 1'b1);
      @(posedge clk);
      rdy <= 1'b0;
      pause(2);
      check(tx, 1'b0);
      wb(REG_CTRL, 1'b1, 32'h5);
      pause(3);
      check(tx, 1'b1);
      @(posedge clk);
      rtx <= 1'b1;
      pause(4 * DIV);
      check(sbusy, 1'b0);
      pause(40);
      check(sbusy, 1'b1);
      rd(REG_STATUS, 32'h0000_001b);
      @(posedge clk);
      rtx <= 1'b0;
      pause(8);
      check(sbusy, 1'b0);
      end_of_test;
   end
   initial begin
      #(40 * 20000);
      mismatches++;
      end_of_test;
   end
endmodule : tb_radio_channel_busy_backoff
`default_nettype wire
